// >>> bench/beacon_reply_checker_asserts.sv
// concurrent checks on the beacon reply parameter logic ports
`timescale 1ns/1ps
`default_nettype none
module beacon_reply_checker
  import beacon_reply_pkg::*;
(
  // clock and reset
  input wire logic                    I_CLOCK,
  input wire logic                    I_RST,
  // inputs
  input wire logic                    I_WR,
  input wire sel_e                    I_WR_SEL,
  input wire logic [23:0]             I_WR_DATA,
  input wire logic                    I_TRIG_PULSE,
  input wire itype_e                  I_RF_ITYPE,
  input wire logic [IID_W-1:0]        I_RF_IID,
  input wire logic                    I_MODE_S_DATA,
  input wire logic                    I_AZIMUTH_NORTH_PULSE,
  input wire logic                    I_TARGET_STROBE,
  // outputs
  input wire logic                    O_WR_REJECT,
  input wire itype_e                  O_ITYPE,
  input wire logic [4*CODE_W-1:0]     O_CODES,
  input wire logic [CODE_W-1:0]       O_ID_FIELD,
  input wire logic                    O_ALERT,
  input wire logic signed [9:0]       O_PW_OFS_NS,
  input wire logic signed [9:0]       O_PS_OFS_NS,
  input wire logic [ADDR_W-1:0]       O_TARGET_ADDR,
  input wire logic [IID_W-1:0]        O_IID,
  input wire logic signed [LVL_W-1:0] O_DELTA_Q,
  input wire logic signed [LVL_W-1:0] O_OMNI_Q,
  input wire logic                    O_AMP_CONFLICT
);
  default clocking @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  itype_route_a: assert property (!I_TRIG_PULSE |=> O_ITYPE == $past(I_RF_ITYPE))
    else $error("rf trigger did not pass decoded type");
  iid_route_a: assert property (!I_TRIG_PULSE |=> O_IID == $past(I_RF_IID))
    else $error("rf trigger did not pass decoded id");
  id_mirror_a: assert property ($stable(O_CODES[47:36]) |-> O_ID_FIELD == O_CODES[47:36])
    else $error("identity field differs from 3/A code");
  // levels from reset are not yet loaded on the first edge, hence the reset guard
  conflict_flag_a: assert property (
    !$past(I_RST) && $stable(O_DELTA_Q) && $stable(O_OMNI_Q)
    |-> O_AMP_CONFLICT == (O_DELTA_Q > DELTA_MAX_Q || O_OMNI_Q > OMNI_MAX_Q))
    else $error("conflict flag wrong for levels");
  data_gate_a: assert property (I_MODE_S_DATA [*2] |=> O_PW_OFS_NS == 0 && O_PS_OFS_NS == 0)
    else $error("offset applied to data pulse");
  freq_refuse_a: assert property (
    I_WR && I_WR_SEL == SEL_FREQ && I_WR_DATA[6:0] > FREQ_MAX_STEP |=> O_WR_REJECT)
    else $error("frequency index above range accepted");
  alert_hold_a: assert property ($rose(O_ALERT) |-> O_ALERT [*8])
    else $error("alert bit dropped early");
  target_step_a: assert property (
    I_TARGET_STROBE && !I_AZIMUTH_NORTH_PULSE && $past(I_TARGET_STROBE)
    |=> O_TARGET_ADDR == $past(O_TARGET_ADDR) + 24'h1)
    else $error("target address did not increment");
  cover property (O_AMP_CONFLICT);
  cover property ($rose(O_ALERT));
  cover property (O_WR_REJECT);
endmodule // beacon_reply_checker
bind beacon_reply_parameter_logic beacon_reply_checker u_beacon_reply_checker (
  .I_CLOCK, .I_RST, .I_WR, .I_WR_SEL, .I_WR_DATA, .I_TRIG_PULSE, .I_RF_ITYPE, .I_RF_IID,
  .I_MODE_S_DATA, .I_AZIMUTH_NORTH_PULSE, .I_TARGET_STROBE, .O_WR_REJECT, .O_ITYPE, .O_CODES,
  .O_ID_FIELD, .O_ALERT, .O_PW_OFS_NS, .O_PS_OFS_NS, .O_TARGET_ADDR, .O_IID, .O_DELTA_Q,
  .O_OMNI_Q, .O_AMP_CONFLICT
);
`default_nettype wire

// >>> bench/beacon_reply_parameter_logic_test.sv
// self-checking testbench for the beacon reply parameter logic
`timescale 1ns/1ps
`default_nettype none
module beacon_reply_parameter_logic_test
  import beacon_reply_pkg::*;
;
  localparam int ACYC = 50;
  localparam logic [17:0] M1K = 18'(ALT_MIN_FT);
  typedef struct {int w; logic [47:0] v; int at;} note_s;
  note_s q[$];
  note_s n;
  int cyc = 0, err_total = 0, total_checks = 0, s, d, o;
  logic [11:0] cw[4];
  logic [3:0] pf[4];
  logic I_CLOCK = 0, I_RST = 1, I_WR = 0, I_TRIG_PULSE = 1;
  logic I_AZIMUTH_NORTH_PULSE = 0, I_TARGET_STROBE = 0, I_MODE_S_DATA;
  sel_e I_WR_SEL = SEL_ITYPE;
  logic [1:0] I_WR_IDX = '0;
  logic [23:0] I_WR_DATA = '0;
  itype_e I_RF_ITYPE, O_ITYPE;
  logic [5:0] I_RF_IID, O_IID;
  logic O_WR_REJECT, O_BUSY, O_CODE_INVALID, O_ALERT, O_SPI, O_ON_GROUND, O_PHASE_180;
  logic O_AMP_CONFLICT, O_RES_25;
  logic [12:0] O_AC_FIELD;
  logic [47:0] O_CODES;
  logic [15:0] O_PULSE_FLAGS;
  logic [17:0] O_ALT_FT;
  logic [11:0] O_ID_FIELD;
  logic [23:0] O_TARGET_ADDR, O_AIRCRAFT_ADDR;
  logic [6:0] O_FREQ_STEP;
  logic signed [9:0] O_PW_OFS_NS, O_PS_OFS_NS, O_SUM_Q, O_DELTA_Q, O_OMNI_Q;
  beacon_reply_parameter_logic #(.ALERT_CYCLES(ACYC)) u_beacon_reply_parameter_logic (
    .I_CLOCK, .I_RST, .I_WR, .I_WR_SEL, .I_WR_IDX, .I_WR_DATA, .I_TRIG_PULSE, .I_RF_ITYPE,
    .I_RF_IID, .I_MODE_S_DATA, .I_AZIMUTH_NORTH_PULSE, .I_TARGET_STROBE, .O_WR_REJECT, .O_BUSY,
    .O_ITYPE, .O_CODES, .O_PULSE_FLAGS, .O_ALT_FT, .O_CODE_INVALID, .O_RES_25, .O_AC_FIELD,
    .O_ID_FIELD, .O_ALERT, .O_PW_OFS_NS, .O_PS_OFS_NS, .O_AIRCRAFT_ADDR, .O_TARGET_ADDR,
    .O_IID, .O_SPI, .O_ON_GROUND, .O_FREQ_STEP, .O_SUM_Q, .O_DELTA_Q, .O_OMNI_Q,
    .O_AMP_CONFLICT, .O_PHASE_180);
  interrogator_model u_interrogator_model (.i_clock(I_CLOCK), .i_pulse_trig(I_TRIG_PULSE),
    .o_rf_itype(I_RF_ITYPE), .o_rf_iid(I_RF_IID), .o_data_pulse(I_MODE_S_DATA));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [47:0] pick(int w);
    case (w)
      0: return O_CODES;
      1: return {O_CODE_INVALID, O_ALT_FT};
      2: return {O_BUSY, O_WR_REJECT};
      3: return O_ITYPE;
      4: return {O_SUM_Q, O_DELTA_Q, O_OMNI_Q, O_AMP_CONFLICT};
      5: return O_ALERT;
      6: return {O_SPI, O_ON_GROUND, O_PHASE_180};
      7: return {O_AIRCRAFT_ADDR, O_TARGET_ADDR};
      8: return O_FREQ_STEP;
      9: return {O_PS_OFS_NS, O_PW_OFS_NS};
      10: return O_PULSE_FLAGS;
      11: return O_ID_FIELD;
      13: return {O_RES_25, O_AC_FIELD};
      default: return O_IID;
    endcase
  endfunction
  function automatic logic [47:0] lv(int s, int d, int o);
    int sq = SUM_BASE_Q + SUM_STEP_Q * s;
    int dq = sq + DRAT_BASE_Q + d;
    int oq = sq - ORAT_BASE_Q - ORAT_STEP_Q * o;
    return {10'(sq), 10'(dq), 10'(oq), dq > DELTA_MAX_Q || oq > OMNI_MAX_Q};
  endfunction
  task automatic wr(sel_e sl, logic [1:0] i, logic [23:0] v);
    @(posedge I_CLOCK);
    I_WR <= 1;
    I_WR_SEL <= sl;
    I_WR_IDX <= i;
    I_WR_DATA <= v;
    @(posedge I_CLOCK);
    I_WR <= 0;
  endtask
  // a note falls due dl edges after the current edge
  task automatic ex(int w, logic [47:0] v, int dl);
    q.push_back('{w, v, cyc + 1 + dl});
  endtask
  task automatic wait_idle();
    int k;
    repeat (3) @(posedge I_CLOCK);
    for (k = 0; k < 4000 && O_BUSY !== 1'b0; k++)
      @(posedge I_CLOCK);
    if (k == 4000)
    begin
      err_total++;
      conclude();
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // clock, cycle count and watcher
  // ----------------------------------------
  initial
  begin
    forever #5 I_CLOCK = ~I_CLOCK;
  end
  always @(posedge I_CLOCK) cyc <= cyc + 1;
  always @(negedge I_CLOCK)
    while (q.size() > 0 && q[0].at <= cyc)
    begin
      n = q.pop_front();
      total_checks++;
      if (pick(n.w) !== n.v)
      begin
        err_total++;
        $display("wrong value at %0t got %h exp %h", $time, pick(n.w), n.v);
      end
    end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'haed60c27));
    repeat (6) @(posedge I_CLOCK);
    I_RST <= 0;
    ex(0, {12'h0, CODE_MINUS_1000, 24'h0}, 0);
    ex(4, lv(0, 0, 0), 1);
    for (int i = 0; i < 8; i++)
    begin
      wr(SEL_ITYPE, 0, 24'(i));
      if (i < 7) ex(3, i, 2);
      else ex(2, 1, 0);
    end
    for (int i = 0; i < 4; i++)
    begin
      cw[i] = 12'($urandom);
      pf[i] = 4'($urandom);
      wr(SEL_CODE, 2'(i), {12'h0, cw[i]});
      wr(SEL_PULSES, 2'(i), {20'h0, pf[i]});
    end
    ex(0, {cw[3], cw[2], cw[1], cw[0]}, 2);
    ex(10, {pf[3], pf[2], pf[1], pf[0]}, 2);
    ex(11, cw[3], 2);
    wr(SEL_ALT, 0, 24'(5000));
    ex(1, {1'b0, 18'(5000)}, 2);
    ex(2, 2'b10, 2);
    wait_idle();
    wr(SEL_CODE, 2, {12'h0, CODE_MINUS_1000});
    ex(1, {1'b0, M1K}, 2);
    wr(SEL_CODE, 2, 24'h0);
    ex(1, {1'b1, M1K}, 2);
    ex(13, {1'b0, 13'h0400}, 2);
    wr(SEL_ALT, 0, 24'(ALT_MIN_FT));
    wait_idle();
    ex(0, {cw[3], CODE_MINUS_1000, cw[1], cw[0]}, 0);
    wr(SEL_RES, 0, 24'h1);
    ex(13, {1'b1, 13'h0010}, 2);
    wr(SEL_CODE, 2, 24'h0);
    ex(2, 1, 0);
    wr(SEL_ALT, 0, 24'(60000));
    ex(2, 1, 0);
    wr(SEL_RES, 0, 24'h0);
    wr(SEL_CODE, 3, {12'h0, ~cw[3]});
    ex(5, 1, 2);
    ex(5, 1, ACYC);
    ex(5, 0, ACYC + 1);
    repeat (ACYC + 4) @(posedge I_CLOCK);
    wr(SEL_FLAGS, 0, 24'h7);
    ex(6, 3'b110, 2);
    repeat (ACYC + 4) @(posedge I_CLOCK);
    ex(5, 1, 0);
    wr(SEL_FLAGS, 0, 24'h8);
    ex(5, 0, 2);
    ex(6, 3'b001, 2);
    wr(SEL_FREQ, 0, 24'd100);
    wr(SEL_FREQ, 0, 24'd101);
    ex(2, 1, 0);
    ex(8, 100, 2);
    wr(SEL_SUM, 0, 24'd191);
    ex(2, 1, 0);
    for (int k = 0; k < 4; k++)
    begin
      s = k < 2 ? 190 : $urandom_range(190);
      d = k == 0 ? 215 : k == 1 ? 0 : $urandom_range(215);
      o = k == 0 ? 0 : k == 1 ? 48 : $urandom_range(48);
      wr(SEL_SUM, 0, 24'(s));
      wr(SEL_DRAT, 0, 24'(d));
      wr(SEL_ORAT, 0, 24'(o));
      repeat (3) @(posedge I_CLOCK);
      ex(4, lv(s, d, o), 0);
    end
    wr(SEL_PS, 0, 24'hf);
    wr(SEL_PW, 0, 24'h5);
    ex(9, {10'(-50), 10'sd250}, 2);
    wr(SEL_PW, 0, 24'h6);
    ex(2, 1, 0);
    wr(SEL_PW, 0, 24'hb);
    ex(9, {10'(-50), 10'(-250)}, 2);
    wr(SEL_IID, 0, 24'd63);
    ex(12, 63, 2);
    wr(SEL_ADDR, 0, 24'hfffffe);
    repeat (3) @(posedge I_CLOCK);
    I_AZIMUTH_NORTH_PULSE <= 1;
    I_TARGET_STROBE <= 1;
    ex(7, {24'hfffffe, 24'hfffffe}, 1);
    @(posedge I_CLOCK);
    I_AZIMUTH_NORTH_PULSE <= 0;
    ex(7, {24'hfffffe, 24'hffffff}, 1);
    @(posedge I_CLOCK);
    ex(7, {24'hfffffe, 24'h0}, 1);
    @(posedge I_CLOCK);
    I_TARGET_STROBE <= 0;
    I_TRIG_PULSE <= 0;
    repeat (30) @(posedge I_CLOCK);
    I_TRIG_PULSE <= 1;
    repeat (4) @(posedge I_CLOCK);
    conclude();
  end
endmodule // beacon_reply_parameter_logic_test
`default_nettype wire

// >>> bench/interrogator_model.sv
// interrogator side model feeding decoded rf interrogations
`timescale 1ns/1ps
`default_nettype none
module interrogator_model
  import beacon_reply_pkg::*;
(
  // clock and trigger mode
  input  wire logic            i_clock,
  input  wire logic            i_pulse_trig,
  // decoded interrogation
  output var itype_e           o_rf_itype = IT_2,
  output var logic [IID_W-1:0] o_rf_iid = '0,
  output var logic             o_data_pulse = 1'b0
);
  // a fresh interrogation every cycle stresses the rf routing hardest
  always @(posedge i_clock)
  begin
    o_rf_itype <= itype_e'($urandom_range(6));
    o_rf_iid <= IID_W'($urandom);
    // data pulses only come with rf-triggered replies
    o_data_pulse <= !i_pulse_trig && 1'($urandom_range(1));
  end
endmodule // interrogator_model
`default_nettype wire

// >>> verilog/beacon_reply_parameter_logic.sv
// reply parameter store, altitude conversion and level checks
`timescale 1ns/1ps
`default_nettype none
module beacon_reply_parameter_logic
  import beacon_reply_pkg::*;
#(
  parameter longint ALERT_CYCLES = ALERT_CYC
)
(
  // clock and reset
  input  wire logic                    I_CLOCK,
  input  wire logic                    I_RST,
  // setting entry
  input  wire logic                    I_WR,
  input  wire sel_e                    I_WR_SEL,
  input  wire logic [1:0]              I_WR_IDX,
  input  wire logic [23:0]             I_WR_DATA,
  // trigger context
  input  wire logic                    I_TRIG_PULSE,
  input  wire itype_e                  I_RF_ITYPE,
  input  wire logic [IID_W-1:0]        I_RF_IID,
  input  wire logic                    I_MODE_S_DATA,
  // target sequencing
  input  wire logic                    I_AZIMUTH_NORTH_PULSE,
  input  wire logic                    I_TARGET_STROBE,
  // entry status
  output logic                         O_WR_REJECT,
  output logic                         O_BUSY,
  // reply content
  output itype_e                       O_ITYPE,
  output logic [4*CODE_W-1:0]          O_CODES,
  output logic [4*PF_W-1:0]            O_PULSE_FLAGS,
  output logic signed [ALT_W-1:0]      O_ALT_FT,
  output logic                         O_CODE_INVALID,
  output logic                         O_RES_25,
  output logic [AC_W-1:0]              O_AC_FIELD,
  output logic [CODE_W-1:0]            O_ID_FIELD,
  output logic                         O_ALERT,
  output logic signed [9:0]            O_PW_OFS_NS,
  output logic signed [9:0]            O_PS_OFS_NS,
  output logic [ADDR_W-1:0]            O_AIRCRAFT_ADDR,
  output logic [ADDR_W-1:0]            O_TARGET_ADDR,
  output logic [IID_W-1:0]             O_IID,
  output logic                         O_SPI,
  output logic                         O_ON_GROUND,
  // rf settings
  output logic [6:0]                   O_FREQ_STEP,
  output logic signed [LVL_W-1:0]      O_SUM_Q,
  output logic signed [LVL_W-1:0]      O_DELTA_Q,
  output logic signed [LVL_W-1:0]      O_OMNI_Q,
  output logic                         O_AMP_CONFLICT,
  output logic                         O_PHASE_180
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (ALERT_CYCLES < 1 || ALERT_CYCLES > 64'hffff_ffff)
    $error("ALERT_CYCLES out of range");

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] gray2bin(input logic [7:0] g);
    logic [7:0] b;
    b[7] = g[7];
    for (int i = 6; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    return b;
  endfunction

  // {C1,C2,C4} to hundreds count 1..5, zero means unmapped
  function automatic logic [2:0] c_dec(input logic [2:0] c);
    case (c)
      3'h1:    return 3'h1;
      3'h3:    return 3'h2;
      3'h2:    return 3'h3;
      3'h6:    return 3'h4;
      3'h4:    return 3'h5;
      default: return 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] c_enc(input logic [2:0] g1);
    case (g1)
      3'h1:    return 3'h1;
      3'h2:    return 3'h3;
      3'h3:    return 3'h2;
      3'h4:    return 3'h6;
      default: return 3'h4;
    endcase
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  itype_e                    itype_r;
  logic [CODE_W-1:0]         code_r [4];
  logic [PF_W-1:0]           pflag_r [4];
  logic signed [ALT_W-1:0]   alt_r;
  logic                      inv_r;
  logic                      res25_r;
  logic signed [3:0]         pw_r;
  logic signed [3:0]         ps_r;
  logic [ADDR_W-1:0]         addr_r;
  logic [ADDR_W-1:0]         tidx_r;
  logic [IID_W-1:0]          iid_r;
  logic [3:0]                flag_r;
  logic [6:0]                freq_r;
  logic [7:0]                sum_r;
  logic [7:0]                drat_r;
  logic [5:0]                orat_r;
  logic [31:0]               alert_cnt_r;
  cv_e                       cv_r;
  logic [16:0]               u_r;
  logic [N25_W-1:0]          n_r;
  logic [1:0]                q_r;
  logic [2:0]                m_r;
  logic [7:0]                g5_r;

  // ----------------------------------------
  // entry decode
  // ----------------------------------------
  wire busy = (cv_r == CV_RUN);
  wire signed [ALT_W-1:0] wr_alt = signed'(I_WR_DATA[ALT_W-1:0]);
  wire signed [3:0] wr_ofs = signed'(I_WR_DATA[3:0]);
  wire alt_max_ok = res25_r ? (int'(wr_alt) <= ALT_MAX25_FT)
                            : (int'(wr_alt) <= ALT_MAX100_FT);
  wire alt_ok  = !busy && int'(wr_alt) >= ALT_MIN_FT && alt_max_ok;
  wire is_c    = (I_WR_IDX == ATC_C);
  wire code_ok = !is_c || (!busy && !res25_r);
  wire ofs_ok  = int'(wr_ofs) <= PW_MAX_STEP && int'(wr_ofs) >= -PW_MAX_STEP;

  logic accept;
  always_comb
  begin
    case (I_WR_SEL)
      SEL_ITYPE: accept = int'(I_WR_DATA[2:0]) <= int'(IT_ROLLCALL_ID);
      SEL_CODE:  accept = code_ok;
      SEL_ALT:   accept = alt_ok;
      SEL_PW:    accept = ofs_ok;
      SEL_PS:    accept = ofs_ok;
      SEL_FREQ:  accept = I_WR_DATA[6:0] <= FREQ_MAX_STEP;
      SEL_SUM:   accept = I_WR_DATA[7:0] <= SUM_MAX_IDX;
      SEL_DRAT:  accept = I_WR_DATA[7:0] <= DRAT_MAX_IDX;
      SEL_ORAT:  accept = I_WR_DATA[5:0] <= ORAT_MAX_IDX;
      default:   accept = 1'b1;
    endcase
  end

  wire wr_ok  = I_WR && accept;
  wire wr_rej = I_WR && !accept;
  wire wr_code = wr_ok && I_WR_SEL == SEL_CODE;
  wire wr_c    = wr_code && is_c;
  wire id_chg  = wr_code && I_WR_IDX == ATC_3A &&
                 I_WR_DATA[CODE_W-1:0] != code_r[ATC_3A];

  // ----------------------------------------
  // mode c code to altitude
  // ----------------------------------------
  wire [CODE_W-1:0] cin = I_WR_DATA[CODE_W-1:0];
  // gray order D2 D4 A1 A2 A4 B1 B2 B4, code is A4A2A1 B4B2B1 C4C2C1 D4D2D1
  wire [7:0] dec_g5 = gray2bin({cin[1], cin[2], cin[9], cin[10], cin[11],
                                cin[6], cin[7], cin[8]});
  wire [2:0] dec_c  = c_dec({cin[3], cin[4], cin[5]});
  wire [2:0] dec_g1 = dec_g5[0] ? 3'(6 - int'(dec_c)) : dec_c;
  wire dec_bad = (dec_c == 3'h0) || cin[0];
  wire signed [ALT_W-1:0] dec_alt = ALT_W'(G5_FT * int'(dec_g5) +
                                           G1_FT * int'(dec_g1) - GILL_OFS_FT);
  wire [N25_W-1:0] dec_n = N25_W'(20 * int'(dec_g5) + 4 * int'(dec_g1) - N_OFS);

  // ----------------------------------------
  // altitude to mode c code
  // ----------------------------------------
  // serial subtraction avoids dividers; worst case about 5100 cycles
  wire [7:0] enc_gray = g5_r ^ (g5_r >> 1);
  wire [2:0] enc_g1   = g5_r[0] ? 3'(5 - int'(m_r)) : 3'(int'(m_r) + 1);
  wire [2:0] enc_c    = c_enc(enc_g1);
  wire [CODE_W-1:0] enc_code = {enc_gray[3], enc_gray[4], enc_gray[5],
                                enc_gray[0], enc_gray[1], enc_gray[2],
                                enc_c[0], enc_c[1], enc_c[2],
                                enc_gray[6], enc_gray[7], 1'b0};
  wire step = (u_r >= 17'(STEP25_FT));

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      cv_r <= CV_IDLE;
      u_r  <= '0;
      n_r  <= '0;
      q_r  <= '0;
      m_r  <= M_START;
      g5_r <= '0;
    end
    else if (wr_ok && I_WR_SEL == SEL_ALT)
    begin
      cv_r <= CV_RUN;
      u_r  <= 17'(int'(wr_alt) - ALT_MIN_FT);
      n_r  <= '0;
      q_r  <= '0;
      m_r  <= M_START;
      g5_r <= '0;
    end
    else if (wr_c)
      n_r <= dec_bad ? '0 : dec_n;
    else
    begin
      case (cv_r)
        CV_RUN:
        if (step)
        begin
          u_r <= u_r - 17'(STEP25_FT);
          n_r <= n_r + 1'b1;
          q_r <= q_r + 1'b1;
          if (q_r == 2'h3)
          begin
            m_r  <= (m_r == 3'h4) ? 3'h0 : m_r + 1'b1;
            g5_r <= (m_r == 3'h4) ? g5_r + 1'b1 : g5_r;
          end
        end
        else
          cv_r <= CV_IDLE;
        default: cv_r <= CV_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // reply codes and altitude
  // ----------------------------------------
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      for (int i = 0; i < 4; i++)
      begin
        code_r[i]  <= '0;
        pflag_r[i] <= '0;
      end
      code_r[ATC_C] <= CODE_MINUS_1000;
      alt_r   <= ALT_W'(ALT_MIN_FT);
      inv_r   <= 1'b0;
      res25_r <= 1'b0;
    end
    else
    begin
      if (wr_code)
        code_r[I_WR_IDX] <= cin;
      // kept apart so a write to another type cannot drop the result
      if (busy && !step)
        code_r[ATC_C] <= enc_code;
      if (wr_ok && I_WR_SEL == SEL_PULSES)
        pflag_r[I_WR_IDX] <= I_WR_DATA[PF_W-1:0];
      if (wr_c)
      begin
        inv_r <= dec_bad;
        alt_r <= dec_bad ? ALT_W'(ALT_MIN_FT) : dec_alt;
      end
      else if (wr_ok && I_WR_SEL == SEL_ALT)
      begin
        inv_r <= 1'b0;
        alt_r <= wr_alt;
      end
      if (wr_ok && I_WR_SEL == SEL_RES)
        res25_r <= I_WR_DATA[0];
    end
  end

  // ----------------------------------------
  // other settings
  // ----------------------------------------
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      itype_r <= IT_3A;
      pw_r    <= '0;
      ps_r    <= '0;
      addr_r  <= '0;
      iid_r   <= '0;
      flag_r  <= '0;
      freq_r  <= '0;
      sum_r   <= '0;
      drat_r  <= '0;
      orat_r  <= '0;
    end
    else if (wr_ok)
    begin
      case (I_WR_SEL)
        SEL_ITYPE: itype_r <= itype_e'(I_WR_DATA[2:0]);
        SEL_PW:    pw_r    <= wr_ofs;
        SEL_PS:    ps_r    <= wr_ofs;
        SEL_ADDR:  addr_r  <= I_WR_DATA[ADDR_W-1:0];
        SEL_IID:   iid_r   <= I_WR_DATA[IID_W-1:0];
        SEL_FLAGS: flag_r  <= I_WR_DATA[3:0];
        SEL_FREQ:  freq_r  <= I_WR_DATA[6:0];
        SEL_SUM:   sum_r   <= I_WR_DATA[7:0];
        SEL_DRAT:  drat_r  <= I_WR_DATA[7:0];
        SEL_ORAT:  orat_r  <= I_WR_DATA[5:0];
        default:   ;
      endcase
    end
  end

  // ----------------------------------------
  // alert timer and target addressing
  // ----------------------------------------
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      alert_cnt_r <= '0;
      tidx_r      <= '0;
    end
    else
    begin
      if (id_chg)
        alert_cnt_r <= 32'(ALERT_CYCLES);
      else if (alert_cnt_r != '0)
        alert_cnt_r <= alert_cnt_r - 1'b1;
      // a strobe in the north pulse cycle is the first target
      if (I_AZIMUTH_NORTH_PULSE)
        tidx_r <= I_TARGET_STROBE ? ADDR_W'(1) : '0;
      else if (I_TARGET_STROBE)
        tidx_r <= tidx_r + 1'b1;
    end
  end

  // ----------------------------------------
  // derived values
  // ----------------------------------------
  wire [CODE_W-1:0] ac_code = inv_r ? CODE_MINUS_1000 : code_r[ATC_C];
  // altitude field order C1 A1 C2 A2 C4 A4 M B1 Q B2 D2 B4 D4
  wire [AC_W-1:0] ac100 = {ac_code[3], ac_code[9], ac_code[4], ac_code[10],
                           ac_code[5], ac_code[11], 1'b0, ac_code[6], 1'b0,
                           ac_code[7], ac_code[1], ac_code[8], ac_code[2]};
  wire [N25_W-1:0] n_use = inv_r ? '0 : n_r;
  wire [AC_W-1:0] ac25 = {n_use[10:5], 1'b0, n_use[4], 1'b1, n_use[3:0]};
  wire [AC_W-1:0] ac_nxt = res25_r ? ac25 : ac100;
  wire [ADDR_W-1:0] taddr_nxt = I_AZIMUTH_NORTH_PULSE ? addr_r
                                                      : addr_r + tidx_r;
  wire alert_nxt = (alert_cnt_r != '0) || flag_r[FL_PERM];
  wire signed [LVL_W-1:0] sum_q  = LVL_W'(SUM_BASE_Q + SUM_STEP_Q * int'(sum_r));
  wire signed [LVL_W-1:0] drat_q = LVL_W'(DRAT_BASE_Q + int'(drat_r));
  wire signed [LVL_W-1:0] orat_q = LVL_W'(ORAT_BASE_Q + ORAT_STEP_Q * int'(orat_r));
  wire signed [LVL_W-1:0] delta_q = sum_q + drat_q;
  wire signed [LVL_W-1:0] omni_q  = sum_q - orat_q;
  wire conflict = int'(delta_q) > DELTA_MAX_Q ||
                  int'(omni_q) > OMNI_MAX_Q;
  wire signed [9:0] pw_ns = I_MODE_S_DATA ? '0 : 10'(int'(pw_r) * PW_STEP_NS);
  wire signed [9:0] ps_ns = I_MODE_S_DATA ? '0 : 10'(int'(ps_r) * PW_STEP_NS);

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      O_WR_REJECT     <= 1'b0;
      O_BUSY          <= 1'b0;
      O_ITYPE         <= IT_3A;
      O_CODES         <= {{CODE_W{1'b0}}, CODE_MINUS_1000, {2*CODE_W{1'b0}}};
      O_PULSE_FLAGS   <= '0;
      O_ALT_FT        <= ALT_W'(ALT_MIN_FT);
      O_CODE_INVALID  <= 1'b0;
      O_RES_25        <= 1'b0;
      O_AC_FIELD      <= '0;
      O_ID_FIELD      <= '0;
      O_ALERT         <= 1'b0;
      O_PW_OFS_NS     <= '0;
      O_PS_OFS_NS     <= '0;
      O_AIRCRAFT_ADDR <= '0;
      O_TARGET_ADDR   <= '0;
      O_IID           <= '0;
      O_SPI           <= 1'b0;
      O_ON_GROUND     <= 1'b0;
      O_FREQ_STEP     <= '0;
      O_SUM_Q         <= '0;
      O_DELTA_Q       <= '0;
      O_OMNI_Q        <= '0;
      O_AMP_CONFLICT  <= 1'b0;
      O_PHASE_180     <= 1'b0;
    end
    else
    begin
      O_WR_REJECT     <= wr_rej;
      O_BUSY          <= busy;
      O_ITYPE         <= I_TRIG_PULSE ? itype_r : I_RF_ITYPE;
      O_CODES         <= {code_r[3], code_r[2], code_r[1], code_r[0]};
      O_PULSE_FLAGS   <= {pflag_r[3], pflag_r[2], pflag_r[1], pflag_r[0]};
      O_ALT_FT        <= alt_r;
      O_CODE_INVALID  <= inv_r;
      O_RES_25        <= res25_r;
      O_AC_FIELD      <= ac_nxt;
      O_ID_FIELD      <= code_r[ATC_3A];
      O_ALERT         <= alert_nxt;
      O_PW_OFS_NS     <= pw_ns;
      O_PS_OFS_NS     <= ps_ns;
      O_AIRCRAFT_ADDR <= addr_r;
      if (I_TARGET_STROBE)
        O_TARGET_ADDR <= taddr_nxt;
      O_IID           <= I_TRIG_PULSE ? iid_r : I_RF_IID;
      O_SPI           <= flag_r[FL_SPI];
      O_ON_GROUND     <= flag_r[FL_GND];
      O_FREQ_STEP     <= freq_r;
      O_SUM_Q         <= sum_q;
      O_DELTA_Q       <= delta_q;
      O_OMNI_Q        <= omni_q;
      O_AMP_CONFLICT  <= conflict;
      O_PHASE_180     <= flag_r[FL_PHASE];
    end
  end

endmodule // beacon_reply_parameter_logic
`default_nettype wire

// >>> verilog/beacon_reply_pkg.sv
// constants, types and widths for the beacon reply parameter logic
package beacon_reply_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam longint CLK_HZ    = 100_000_000;
  localparam longint ALERT_S   = 18;
  localparam longint ALERT_CYC = ALERT_S * CLK_HZ;
  localparam int PW_STEP_NS    = 50;
  localparam int PW_LIMIT_NS   = 250;
  localparam int PW_MAX_STEP   = PW_LIMIT_NS / PW_STEP_NS;
  // ----------------------------------------
  // widths and indices
  // ----------------------------------------
  localparam int ALT_W  = 18;
  localparam int CODE_W = 12;
  localparam int ADDR_W = 24;
  localparam int IID_W  = 6;
  localparam int AC_W   = 13;
  localparam int LVL_W  = 10;
  localparam int N25_W  = 11;
  localparam logic [1:0] ATC_C  = 2'h2;
  localparam logic [1:0] ATC_3A = 2'h3;
  localparam int PF_W = 4;
  localparam int FL_SPI = 0, FL_GND = 1, FL_PERM = 2, FL_PHASE = 3;
  // ----------------------------------------
  // altitude encoding
  // ----------------------------------------
  localparam int ALT_MIN_FT    = -1000;
  localparam int ALT_MAX100_FT = 126700;
  localparam int ALT_MAX25_FT  = 50175;
  localparam int STEP25_FT     = 25;
  localparam int G5_FT         = 500;
  localparam int G1_FT         = 100;
  localparam int GILL_OFS_FT   = 1300;
  localparam int N_OFS         = 12;
  localparam logic [2:0] M_START = 3'h2;
  localparam logic [CODE_W-1:0] CODE_MINUS_1000 = 12'h010;
  // ----------------------------------------
  // rf setting ranges, levels in quarter dB
  // ----------------------------------------
  localparam logic [6:0] FREQ_MAX_STEP = 7'h64;
  localparam logic [7:0] SUM_MAX_IDX   = 8'hbe;
  localparam logic [7:0] DRAT_MAX_IDX  = 8'hd7;
  localparam logic [5:0] ORAT_MAX_IDX  = 6'h30;
  localparam int SUM_BASE_Q  = -340;
  localparam int SUM_STEP_Q  = 2;
  localparam int DRAT_BASE_Q = -167;
  localparam int ORAT_BASE_Q = -112;
  localparam int ORAT_STEP_Q = 4;
  localparam int DELTA_MAX_Q = 64;
  localparam int OMNI_MAX_Q  = -40;
  // ----------------------------------------
  // enumerations
  // ----------------------------------------
  typedef enum logic [2:0] {
    IT_2, IT_B, IT_C, IT_3A, IT_ALL_CALL, IT_ROLLCALL_ALT, IT_ROLLCALL_ID
  } itype_e;
  typedef enum logic [3:0] {
    SEL_ITYPE, SEL_CODE, SEL_PULSES, SEL_ALT, SEL_RES, SEL_PW, SEL_PS,
    SEL_ADDR, SEL_IID, SEL_FLAGS, SEL_FREQ, SEL_SUM, SEL_DRAT, SEL_ORAT
  } sel_e;
  typedef enum logic {CV_IDLE, CV_RUN} cv_e;
endpackage
